// ---- shared/pso_pkg.sv ----
// Package of constants, carriers and helpers for the parameter store block
package pso_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Message services and request path
  localparam logic [7:0] SVC_READ = 8'h32;
  localparam logic [7:0] SVC_WRITE = 8'h33;
  localparam logic [7:0] SVC_READ_ALT = 8'h34;
  localparam logic [7:0] SVC_REPLY_BIT = 8'h80;
  localparam logic [7:0] PATH_WORDS = 8'h02;
  localparam logic [7:0] SEG_CLASS = 8'h20;
  localparam logic [7:0] CLASS_OD = 8'h64;
  localparam logic [7:0] SEG_INST = 8'h24;
  localparam logic [7:0] INST_OD = 8'h01;
  localparam logic [3:0] LEN_READ = 4'h9;
  localparam logic [3:0] LEN_WRITE = 4'hA;
  localparam logic [3:0] LAST_SHORT = 4'h3;
  localparam logic [3:0] LAST_READ = 4'h7;
  localparam logic [3:0] LAST_ALT = 4'hB;
  localparam logic [15:0] ALT_TYPE = 16'h0007;
  localparam logic [15:0] ALT_LEN = 16'h0004;

  // General status codes of a reply
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BAD_PATH = 8'h05;
  localparam logic [7:0] ST_BAD_SVC = 8'h08;
  localparam logic [7:0] ST_BAD_VAL = 8'h09;
  localparam logic [7:0] ST_BUSY = 8'h0C;
  localparam logic [7:0] ST_SHORT = 8'h13;
  localparam logic [7:0] ST_NO_OBJ = 8'h16;

  ////////////////////////////////////////////////////////////////////////////
  // Dictionary indices and subindices
  localparam logic [15:0] IDX_STORE = 16'h1010;
  localparam logic [15:0] IDX_RESTORE = 16'h1011;
  localparam logic [15:0] IDX_MARKER = 16'h1020;
  localparam logic [15:0] IDX_REBOOT = 16'h2800;
  localparam logic [15:0] IDX_MODES = 16'h6060;
  localparam logic [15:0] IDX_TUNE = 16'h2031;
  localparam logic [15:0] IDX_ETH = 16'h2011;
  localparam logic [15:0] IDX_USER = 16'h2701;
  localparam logic [15:0] IDX_COMM = 16'h3501;
  localparam logic [15:0] IDX_MOVE = 16'h6073;
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_ALL = 8'h01;
  localparam logic [7:0] SUB_COMM = 8'h02;
  localparam logic [7:0] SUB_APP = 8'h03;
  localparam logic [7:0] SUB_USER = 8'h04;
  localparam logic [7:0] SUB_MOVE = 8'h05;
  localparam logic [7:0] SUB_TUNE = 8'h06;
  localparam logic [7:0] SUB_ETH = 8'h0C;
  localparam logic [7:0] SUB_DATE = 8'h01;
  localparam logic [7:0] SUB_TIME = 8'h02;
  localparam logic [2:0] CODE_ETH = 3'h6;

  // Signatures and fixed values
  localparam logic [31:0] SIG_SAVE = 32'h6576_6173;
  localparam logic [31:0] SIG_DISCARD = 32'h6461_6F6C;
  localparam logic [31:0] SIG_BOOT = 32'h746F_6F62;
  localparam logic [31:0] SAVE_DONE = 32'h0000_0001;
  localparam logic [31:0] MARK_CLEAR = 32'h0000_0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // Cyclic drive-profile mode numbers that are refused
  localparam logic [7:0] MODE_IP = 8'h07;
  localparam logic [7:0] MODE_CSP = 8'h08;
  localparam logic [7:0] MODE_CSV = 8'h09;
  localparam logic [7:0] MODE_CST = 8'h0A;

  ////////////////////////////////////////////////////////////////////////////
  // Category mask bits: comm, app, user, move, tune, eth, marker
  localparam int CAT_W = 7;
  localparam logic [6:0] CAT_NONE = 7'h00;
  localparam logic [6:0] CAT_COMM = 7'h01;
  localparam logic [6:0] CAT_APP = 7'h02;
  localparam logic [6:0] CAT_USER = 7'h04;
  localparam logic [6:0] CAT_MOVE = 7'h08;
  localparam logic [6:0] CAT_TUNE = 7'h10;
  localparam logic [6:0] CAT_ETH = 7'h20;
  localparam logic [6:0] CAT_ALL_SAVE = 7'h5F;
  localparam logic [6:0] CAT_ALL_DISCARD = 7'h4F;

  // Memory slots of the dictionary store
  localparam int OD_AW = 5;
  localparam int OD_DEPTH = 32;
  localparam logic [4:0] SLOT_RESTORE_BASE = 5'h08;
  localparam logic [4:0] SLOT_REBOOT = 5'h10;
  localparam logic [4:0] SLOT_MODES = 5'h11;
  localparam logic [4:0] SLOT_TUNE = 5'h12;
  localparam logic [4:0] SLOT_ETH = 5'h13;
  localparam logic [4:0] SLOT_USER = 5'h14;
  localparam logic [4:0] SLOT_COMM = 5'h15;
  localparam logic [4:0] SLOT_MOVE = 5'h16;

  typedef struct packed {
    logic hit;
    logic [4:0] slot;
    logic savable;
    logic marker;
  } pso_slot_t;

  // Request towards the non-volatile memory engine
  typedef struct packed {
    logic req;
    logic discard;
    logic [6:0] cats;
  } pso_nvm_req_t;

  // Subindex to category mask, shared by store and restore
  function automatic logic [6:0] pso_cat_mask(input logic [7:0] sub, input logic discard);
    logic [6:0] m;
    m = CAT_NONE;
    case (sub)
      SUB_ALL: m = discard ? CAT_ALL_DISCARD : CAT_ALL_SAVE;
      SUB_COMM: m = CAT_COMM;
      SUB_APP: m = CAT_APP;
      SUB_USER: m = CAT_USER;
      SUB_MOVE: m = CAT_MOVE;
      SUB_TUNE: m = CAT_TUNE;
      SUB_ETH: m = CAT_ETH;
      default: m = CAT_NONE;
    endcase
    return m;
  endfunction

  // Index/subindex to storage slot
  function automatic pso_slot_t pso_slot_lookup(input logic [15:0] idx, input logic [7:0] sub);
    pso_slot_t s;
    logic [2:0] code;
    s = '0;
    code = (sub == SUB_ETH) ? CODE_ETH : 3'(sub[2:0] - 3'h1);
    if (idx == IDX_STORE || idx == IDX_RESTORE) begin
      s.hit = (pso_cat_mask(sub, 1'b0) != CAT_NONE);
      s.slot = (idx == IDX_RESTORE) ? (SLOT_RESTORE_BASE | {2'b00, code}) : {2'b00, code};
      s.savable = (idx == IDX_STORE);
    end else if (idx == IDX_MARKER) begin
      s.hit = (sub == SUB_DATE) || (sub == SUB_TIME);
      s.savable = 1'b1;
      s.marker = 1'b1;
    end else begin
      s.savable = 1'b1;
      s.hit = 1'b1;
      case (idx)
        IDX_REBOOT: s.slot = SLOT_REBOOT;
        IDX_MODES: s.slot = SLOT_MODES;
        IDX_TUNE: s.slot = SLOT_TUNE;
        IDX_ETH: s.slot = SLOT_ETH;
        IDX_USER: s.slot = SLOT_USER;
        IDX_COMM: s.slot = SLOT_COMM;
        IDX_MOVE: s.slot = SLOT_MOVE;
        default: s.hit = 1'b0;
      endcase
      if (idx == IDX_REBOOT || idx == IDX_USER || idx == IDX_COMM) begin
        s.hit = s.hit && (sub == SUB_ALL);
      end else begin
        s.hit = s.hit && (sub == SUB_ZERO);
      end
    end
    return s;
  endfunction

endpackage

// ---- verilog/pso_od_ram.sv ----
// Small dictionary storage with registered read data
`timescale 1ns/1ps
module pso_od_ram
  import pso_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [OD_AW-1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [OD_AW-1:0] raddr_i,
  output logic [31:0] rdata_o
);

  logic [31:0] mem_reg [OD_DEPTH];

  // Storage words, cleared at reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < OD_DEPTH; i++) begin
        mem_reg[i] <= WORD_RESET;
      end
    end else if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= WORD_RESET;
    end else begin
      rdata_o <= mem_reg[raddr_i];
    end
  end

endmodule

// ---- verilog/pso_nvm_seq.sv ----
// Sequencer for save and discard operations of the non-volatile memory
`timescale 1ns/1ps
module pso_nvm_seq
  import pso_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic discard_i,
  input wire logic [CAT_W-1:0] cats_i,
  input wire logic [OD_AW-1:0] slot_i,
  input wire logic nvm_done_i,
  input wire logic ack_i,
  output logic busy_o,
  output logic fin_o,
  output logic fin_save_o,
  output logic [OD_AW-1:0] fin_slot_o,
  output pso_nvm_req_t nvm_o
);

  typedef enum logic [1:0] {SQ_IDLE, SQ_REQ, SQ_FIN} pso_sq_t;
  pso_sq_t state_reg;

  assign busy_o = (state_reg != SQ_IDLE);
  assign fin_o = (state_reg == SQ_FIN);

  // Request held to the memory engine until it reports done
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= SQ_IDLE;
      nvm_o <= '0;
      fin_save_o <= 1'b0;
      fin_slot_o <= '0;
    end else begin
      unique case (state_reg)
        SQ_IDLE: if (start_i) begin
          nvm_o <= '{req: 1'b1, discard: discard_i, cats: cats_i};
          fin_save_o <= !discard_i;
          fin_slot_o <= slot_i;
          state_reg <= SQ_REQ;
        end
        SQ_REQ: if (nvm_done_i) begin
          nvm_o.req <= 1'b0;
          state_reg <= SQ_FIN;
        end
        SQ_FIN: if (ack_i) begin
          state_reg <= SQ_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- verilog/pso_param_store.sv ----
// Object access service and parameter store control
`timescale 1ns/1ps
module pso_param_store
  import pso_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output pso_nvm_req_t nvm_o,
  input wire logic nvm_done_i,
  output logic reboot_o
);

  typedef enum logic [1:0] {PS_RX, PS_EXEC, PS_RDW, PS_TX} pso_state_t;

  pso_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] svc_reg;
  logic [15:0] idx_reg;
  logic [7:0] sub_reg;
  logic [31:0] val_reg;
  logic [7:0] err_reg;
  logic [7:0] status_reg;
  logic [3:0] rlen_reg;
  logic [3:0] pos_reg;
  logic [31:0] mark_reg [2];
  logic boot_reg;
  logic rx_ready_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Reply byte layout: plain read and alternate read
  function automatic logic [7:0] reply_byte(input logic [3:0] p, input logic [7:0] svc,
                                            input logic [7:0] st, input logic [31:0] v);
    logic alt;
    logic [7:0] b;
    alt = (svc == SVC_READ_ALT);
    b = 8'h00;
    case (p)
      4'h0: b = svc | SVC_REPLY_BIT;
      4'h2: b = st;
      4'h4: b = alt ? ALT_TYPE[7:0] : v[7:0];
      4'h5: b = alt ? ALT_TYPE[15:8] : v[15:8];
      4'h6: b = alt ? ALT_LEN[7:0] : v[23:16];
      4'h7: b = alt ? ALT_LEN[15:8] : v[31:24];
      4'h8: b = v[7:0];
      4'h9: b = v[15:8];
      4'hA: b = v[23:16];
      4'hB: b = v[31:24];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request byte checks
  wire logic take = rx_valid_i && rx_ready_reg;
  wire logic [7:0] exp_byte = (cnt_reg == 4'h1) ? PATH_WORDS :
                              (cnt_reg == 4'h2) ? SEG_CLASS :
                              (cnt_reg == 4'h3) ? CLASS_OD :
                              (cnt_reg == 4'h4) ? SEG_INST : INST_OD;
  wire logic path_pos = (cnt_reg >= 4'h1) && (cnt_reg <= 4'h5);
  wire logic byte_err = path_pos && (rx_data_i != exp_byte);
  wire logic [1:0] lane = 2'(cnt_reg - 4'h9);
  wire logic val_pos = (cnt_reg >= 4'h9) && (cnt_reg <= 4'hC);

  // Decode of the addressed entry and of the service
  wire pso_slot_t slot_w = pso_slot_lookup(idx_reg, sub_reg);
  wire logic is_wr = (svc_reg == SVC_WRITE);
  wire logic is_rd = (svc_reg == SVC_READ) || (svc_reg == SVC_READ_ALT);
  wire logic svc_ok = is_wr || is_rd;
  wire logic is_store = (idx_reg == IDX_STORE);
  wire logic is_restore = (idx_reg == IDX_RESTORE);
  wire logic too_short = cnt_reg < (is_wr ? LEN_WRITE : LEN_READ);
  wire logic trig_save = is_store && (val_reg == SIG_SAVE);
  wire logic trig_disc = is_restore && (val_reg == SIG_DISCARD);
  wire logic trig_boot = (slot_w.slot == SLOT_REBOOT) && !slot_w.marker &&
                         (idx_reg == IDX_REBOOT) && (val_reg == SIG_BOOT);
  wire logic cyc_mode = (val_reg[7:0] == MODE_IP) || (val_reg[7:0] == MODE_CSP) ||
                        (val_reg[7:0] == MODE_CSV) || (val_reg[7:0] == MODE_CST);
  wire logic cyc_bad = (idx_reg == IDX_MODES) && cyc_mode;
  wire logic seq_busy;
  wire logic seq_fin;
  wire logic seq_fin_save;
  wire logic [OD_AW-1:0] seq_fin_slot;
  wire logic [31:0] ram_rdata;

  // Status of the request: path fault first, then service, length, entry, busy, value
  wire logic [7:0] exec_status = (err_reg != ST_OK) ? err_reg :
                                 !svc_ok ? ST_BAD_SVC :
                                 too_short ? ST_SHORT :
                                 !slot_w.hit ? ST_NO_OBJ :
                                 (is_wr && (trig_save || trig_disc) && seq_busy) ? ST_BUSY :
                                 (is_wr && cyc_bad) ? ST_BAD_VAL : ST_OK;
  wire logic in_exec = (state_reg == PS_EXEC);
  wire logic wr_ok = in_exec && is_wr && (exec_status == ST_OK);
  wire logic mark_wr = wr_ok && slot_w.marker;
  wire logic mark_clr = wr_ok && slot_w.savable && !slot_w.marker &&
                        !(is_store && sub_reg == SUB_ALL);
  wire logic seq_start = wr_ok && (trig_save || trig_disc);
  wire logic [CAT_W-1:0] seq_cats = pso_cat_mask(sub_reg, trig_disc);
  wire logic fin_ack = seq_fin && !wr_ok;

  // Storage write port: request data first, completion value when free
  wire logic ram_we = (wr_ok && !slot_w.marker) || (fin_ack && seq_fin_save);
  wire logic [OD_AW-1:0] ram_waddr = wr_ok ? slot_w.slot : seq_fin_slot;
  wire logic [31:0] ram_wdata = wr_ok ? val_reg : SAVE_DONE;
  wire logic [31:0] rd_word = slot_w.marker ? mark_reg[sub_reg[1]] : ram_rdata;
  wire logic [3:0] rlen_w = (exec_status != ST_OK || is_wr) ? LAST_SHORT :
                            (svc_reg == SVC_READ_ALT) ? LAST_ALT : LAST_READ;
  wire logic tx_hs = tx_valid_o && tx_ready_i;
  wire logic [3:0] pos_nxt = 4'(pos_reg + 4'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Dictionary storage and save sequencer
  pso_od_ram u_ram (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(ram_we),
    .waddr_i(ram_waddr),
    .wdata_i(ram_wdata),
    .raddr_i(slot_w.slot),
    .rdata_o(ram_rdata)
  );

  // Discard only touches the saved copy; working values stay until restart
  pso_nvm_seq u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(seq_start),
    .discard_i(trig_disc),
    .cats_i(seq_cats),
    .slot_i(slot_w.slot),
    .nvm_done_i(nvm_done_i),
    .ack_i(fin_ack),
    .busy_o(seq_busy),
    .fin_o(seq_fin),
    .fin_save_o(seq_fin_save),
    .fin_slot_o(seq_fin_slot),
    .nvm_o(nvm_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request capture; any transport delivers the same byte stream
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 4'h0;
      svc_reg <= 8'h00;
      idx_reg <= 16'h0000;
      sub_reg <= 8'h00;
      err_reg <= ST_OK;
    end else if (take) begin
      cnt_reg <= (cnt_reg == 4'hF) ? cnt_reg : 4'(cnt_reg + 4'h1);
      if (cnt_reg == 4'h0) svc_reg <= rx_data_i;
      if (cnt_reg == 4'h6) idx_reg[7:0] <= rx_data_i;
      if (cnt_reg == 4'h7) idx_reg[15:8] <= rx_data_i;
      if (cnt_reg == 4'h8) sub_reg <= rx_data_i;
      if (byte_err && err_reg == ST_OK) err_reg <= ST_BAD_PATH;
    end else if (state_reg == PS_TX && tx_hs && pos_reg == rlen_reg) begin
      cnt_reg <= 4'h0;
      err_reg <= ST_OK;
    end
  end

  // Value word: little-endian write data, then read data for the reply
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      val_reg <= WORD_RESET;
    end else if (take && val_pos) begin
      val_reg[lane*8 +: 8] <= rx_data_i;
    end else if (state_reg == PS_RDW) begin
      val_reg <= rd_word;
    end else if (state_reg == PS_TX && tx_hs && pos_reg == rlen_reg) begin
      val_reg <= WORD_RESET;
    end
  end

  // Request and reply sequencing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= PS_RX;
      rx_ready_reg <= 1'b1;
      status_reg <= ST_OK;
      rlen_reg <= LAST_SHORT;
    end else begin
      unique case (state_reg)
        PS_RX: if (take && rx_last_i) begin
          rx_ready_reg <= 1'b0;
          state_reg <= PS_EXEC;
        end
        PS_EXEC: begin
          status_reg <= exec_status;
          rlen_reg <= rlen_w;
          state_reg <= (exec_status == ST_OK && is_rd) ? PS_RDW : PS_TX;
        end
        PS_RDW: state_reg <= PS_TX;
        PS_TX: if (tx_hs && pos_reg == rlen_reg) begin
          rx_ready_reg <= 1'b1;
          state_reg <= PS_RX;
        end
      endcase
    end
  end

  // Reply byte stream
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_last_o <= 1'b0;
      pos_reg <= 4'h0;
    end else if ((in_exec && !(exec_status == ST_OK && is_rd)) || state_reg == PS_RDW) begin
      tx_valid_o <= 1'b1;
      tx_data_o <= svc_reg | SVC_REPLY_BIT;
      tx_last_o <= 1'b0;
      pos_reg <= 4'h0;
    end else if (state_reg == PS_TX && tx_hs) begin
      tx_valid_o <= (pos_reg != rlen_reg);
      tx_data_o <= reply_byte(pos_nxt, svc_reg, status_reg, val_reg);
      tx_last_o <= (pos_nxt == rlen_reg) && (pos_reg != rlen_reg);
      pos_reg <= pos_nxt;
    end
  end

  // Configuration markers: written by the master, cleared by other savable writes except save-all
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mark_reg[0] <= MARK_CLEAR;
      mark_reg[1] <= MARK_CLEAR;
    end else if (mark_wr) begin
      mark_reg[sub_reg[1]] <= val_reg;
    end else if (mark_clr) begin
      mark_reg[0] <= MARK_CLEAR;
      mark_reg[1] <= MARK_CLEAR;
    end
  end

  // Restart pulse on the boot signature
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_reg <= 1'b0;
    end else begin
      boot_reg <= wr_ok && trig_boot;
    end
  end

  assign reboot_o = boot_reg;
  assign rx_ready_o = rx_ready_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks next to the logic they guard
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_boot_pulse;
    reboot_o ##1 !reboot_o;
  endsequence

  sequence s_save_taken;
    wr_ok && trig_save && is_store;
  endsequence

  AST_SAVE_START: assert property (s_save_taken |=> nvm_o.req && !nvm_o.discard)
    else $error("Save signature did not start a save");

  AST_SAVE_DONE: assert property (fin_ack && seq_fin_save |->
      ram_we && ram_waddr == seq_fin_slot && ram_wdata == SAVE_DONE)
    else $error("Finished save did not write one to its subindex");

  AST_SAVE_ALL_CATS: assert property ((s_save_taken and sub_reg == SUB_ALL) |=>
      nvm_o.cats == CAT_ALL_SAVE)
    else $error("Save-all category mask wrong");

  AST_RESTORE_ALL: assert property (wr_ok && trig_disc && sub_reg == SUB_ALL |=>
      nvm_o.discard && (nvm_o.cats & (CAT_TUNE | CAT_ETH)) == CAT_NONE)
    else $error("Factory restore touched tuning or Ethernet");

  AST_DISCARD_KEEP: assert property (wr_ok && trig_disc |-> ram_we &&
      (ram_waddr & SLOT_RESTORE_BASE) == SLOT_RESTORE_BASE && ram_waddr < SLOT_REBOOT)
    else $error("Discard altered another working value");

  AST_BOOT: assert property (wr_ok && trig_boot |=> s_boot_pulse)
    else $error("Boot signature did not give one restart pulse");

  AST_MARK_CLEAR: assert property (mark_clr |=>
      mark_reg[0] == MARK_CLEAR && mark_reg[1] == MARK_CLEAR)
    else $error("Marker not cleared by a savable write");

  AST_MARK_KEEP: assert property (wr_ok && is_store && sub_reg == SUB_ALL |=>
      mark_reg[0] == $past(mark_reg[0]) && mark_reg[1] == $past(mark_reg[1]))
    else $error("Save-all write cleared the marker");

  AST_SERVICE: assert property (in_exec && !svc_ok && err_reg == ST_OK |=>
      status_reg == ST_BAD_SVC)
    else $error("Unknown service not refused");

  AST_NO_CYCLIC: assert property (in_exec && is_wr && cyc_bad && err_reg == ST_OK &&
      !too_short |-> !ram_we || !wr_ok)
    else $error("Cyclic mode was accepted");

  AST_REPLY_HEAD: assert property (state_reg == PS_RDW |=>
      tx_valid_o && tx_data_o == (svc_reg | SVC_REPLY_BIT) ##1 !tx_last_o)
    else $error("Reply does not open with the echoed service");

endmodule

// ---- sim/pso_nvm_model.sv ----
// Memory engine model that finishes save and discard requests
`timescale 1ns/1ps
module pso_nvm_model
  import pso_pkg::*;
#(parameter int DLY = 40)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pso_nvm_req_t nvm_i,
  output logic done_o
);
  int cnt;
  // Whole-category job ends with a one-cycle pulse after a fixed delay
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (nvm_i.req && !done_o) begin
        cnt <= (cnt == DLY) ? 0 : cnt + 1;
        done_o <= (cnt == DLY);
      end
    end
  end
endmodule

// ---- sim/tb.sv ----
// Testbench for the parameter store object access block
`timescale 1ns/1ps
module tb;
  import pso_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rx_valid_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  logic rx_last_i = 1'b0;
  logic tx_ready_i = 1'b0;
  logic rx_ready_o, tx_valid_o, tx_last_o, reboot_o, nvm_done_i;
  logic [7:0] tx_data_o;
  pso_nvm_req_t nvm_o;
  logic [7:0] rp[$];
  logic [7:0] cls = CLASS_OD;
  logic [7:0] subs[6] = '{SUB_COMM, SUB_APP, SUB_USER, SUB_MOVE, SUB_TUNE, SUB_ETH};
  logic [6:0] cats[6] = '{CAT_COMM, CAT_APP, CAT_USER, CAT_MOVE, CAT_TUNE, CAT_ETH};
  int n_fail = 0;
  int tests_run = 0;
  int n_boot = 0;
  pso_param_store pso_param_store_inst (.clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
    .tx_ready_i(tx_ready_i), .nvm_o(nvm_o), .nvm_done_i(nvm_done_i), .reboot_o(reboot_o));
  pso_nvm_model pso_nvm_model_inst (.clk_i(clk_i), .rst_i(rst_i), .nvm_i(nvm_o),
    .done_o(nvm_done_i));
  always #25 clk_i = ~clk_i;
  // Count restart pulses
  always @(posedge clk_i) if (reboot_o === 1'b1) n_boot++;
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One request out, whole reply back, sink stalling a cycle per byte
  task automatic xfer(input logic [7:0] svc, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] v, input int nv);
    logic [7:0] q[$];
    logic fin;
    q = {svc, PATH_WORDS, SEG_CLASS, cls, SEG_INST, INST_OD, idx[7:0], idx[15:8], sub};
    for (int i = 0; i < nv; i++) q.push_back(v[8*i+:8]);
    for (int i = 0; i < q.size(); i++) begin
      rx_valid_i = 1'b1;
      rx_data_i = q[i];
      rx_last_i = (i == q.size() - 1);
      while (rx_ready_o !== 1'b1) tick();
      tick();
    end
    rx_valid_i = 1'b0;
    rx_last_i = 1'b0;
    rp = {};
    fin = 1'b0;
    while (!fin) begin
      while (tx_valid_o !== 1'b1) tick();
      rp.push_back(tx_data_o);
      fin = tx_last_o;
      tx_ready_i = 1'b1;
      tick();
      tx_ready_i = 1'b0;
      tick();
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] v,
                    input logic [7:0] st);
    xfer(SVC_WRITE, idx, sub, v, 4);
    chk("write reply", {16'h0000, rp[0], rp[2]}, {16'h0000, SVC_WRITE | SVC_REPLY_BIT, st});
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] v);
    xfer(SVC_READ, idx, sub, 32'h0000_0000, 0);
    chk("read reply", {rp[0], rp[2], rp[3], rp[1]}, {SVC_READ | SVC_REPLY_BIT, ST_OK, 16'h0000});
    chk("read value", {rp[7], rp[6], rp[5], rp[4]}, v);
  endtask
  // Read the trigger subindex until the save reports done
  task automatic poll(input logic [7:0] sub);
    for (int i = 0; i < 20; i++) begin
      xfer(SVC_READ, IDX_STORE, sub, 32'h0000_0000, 0);
      if ({rp[7], rp[6], rp[5], rp[4]} === SAVE_DONE) break;
    end
    rd(IDX_STORE, sub, SAVE_DONE);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    wr(IDX_TUNE, SUB_ZERO, 32'h0000_0304, ST_OK);
    rd(IDX_TUNE, SUB_ZERO, 32'h0000_0304);
    xfer(SVC_READ_ALT, IDX_TUNE, SUB_ZERO, 32'h0000_0000, 0);
    chk("alt reply", {rp[0], rp[4], rp[6], rp[8]}, {8'hB4, ALT_TYPE[7:0], ALT_LEN[7:0], 8'h04});
    xfer(8'h35, IDX_TUNE, SUB_ZERO, 32'h0000_0000, 0);
    chk("bad service", {24'h00_0000, rp[2]}, {24'h00_0000, ST_BAD_SVC});
    cls = 8'h65;
    xfer(SVC_READ, IDX_TUNE, SUB_ZERO, 32'h0000_0000, 0);
    cls = CLASS_OD;
    chk("bad path", {24'h00_0000, rp[2]}, {24'h00_0000, ST_BAD_PATH});
    xfer(SVC_WRITE, IDX_TUNE, SUB_ZERO, 32'h0000_0099, 0);
    chk("short write", {24'h00_0000, rp[2]}, {24'h00_0000, ST_SHORT});
    xfer(SVC_WRITE, IDX_USER, SUB_ALL, 32'hAABB_CC55, 1);
    chk("one byte write", {24'h00_0000, rp[2]}, {24'h00_0000, ST_OK});
    rd(IDX_USER, SUB_ALL, 32'h0000_0055);
    wr(IDX_MARKER, SUB_DATE, 32'h0A0B_0C0D, ST_OK);
    wr(IDX_MARKER, SUB_TIME, 32'h0E0F_1011, ST_OK);
    wr(IDX_STORE, SUB_ALL, SIG_SAVE, ST_OK);
    chk("save all", 32'(nvm_o), 32'({2'b10, CAT_ALL_SAVE}));
    wr(IDX_STORE, SUB_COMM, SIG_SAVE, ST_BUSY);
    poll(SUB_ALL);
    rd(IDX_MARKER, SUB_DATE, 32'h0A0B_0C0D);
    rd(IDX_MARKER, SUB_TIME, 32'h0E0F_1011);
    for (int k = 0; k < 6; k++) begin
      wr(IDX_STORE, subs[k], SIG_SAVE, ST_OK);
      chk("save cat", 32'(nvm_o), 32'({2'b10, cats[k]}));
      poll(subs[k]);
      wr(IDX_RESTORE, subs[k], SIG_DISCARD, ST_OK);
      chk("discard cat", 32'(nvm_o), 32'({2'b11, cats[k]}));
      while (nvm_o.req === 1'b1) tick();
    end
    rd(IDX_MARKER, SUB_DATE, MARK_CLEAR);
    wr(IDX_RESTORE, SUB_ALL, SIG_DISCARD, ST_OK);
    chk("discard all", 32'(nvm_o), 32'({2'b11, CAT_ALL_DISCARD}));
    while (nvm_o.req === 1'b1) tick();
    rd(IDX_TUNE, SUB_ZERO, 32'h0000_0304);
    wr(IDX_STORE, 8'h07, SIG_SAVE, ST_NO_OBJ);
    for (int m = 7; m < 11; m++) wr(IDX_MODES, SUB_ZERO, 32'(m), ST_BAD_VAL);
    chk("no restart", 32'(n_boot), 32'h0000_0000);
    wr(IDX_REBOOT, SUB_ALL, SIG_BOOT, ST_OK);
    tick();
    chk("restart", 32'(n_boot), 32'h0000_0001);
    stop_test();
  end
  // Watchdog well beyond the expected few thousand cycles
  initial begin
    #(50 * 60000);
    n_fail++;
    stop_test();
  end
endmodule
